/* rtl/uhf_pkg.sv */
package uhf_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_HOST_CONFIG    = 8'h00;
    localparam logic [7:0] OFF_FRAME_INTERVAL = 8'h04;
    localparam logic [7:0] OFF_FRAME_NUMBER   = 8'h08;
    localparam logic [7:0] OFF_PERIODIC_TX    = 8'h0C;
    localparam logic [7:0] OFF_CH_SUMMARY     = 8'h10;
    localparam logic [7:0] OFF_CH_MASK        = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h1C;

    // Field positions, interrupt field width and channel count
    localparam int HCFG_FS_LS_ONLY_BIT  = 2;
    localparam int HFIR_RELOAD_CTRL_BIT = 16;
    localparam int IRQ_SOF_BIT          = 0;
    localparam int IRQ_FRAME_WRAP_BIT   = 1;
    localparam int IRQ_CHANNEL_BIT      = 2;
    localparam int IRQ_WIDTH            = 3;
    localparam int NUM_CHANNELS         = 16;

    // Reset values and the frame number wrap limit
    localparam logic [15:0] FRAME_INTERVAL_RST = 16'hEA60;
    localparam logic [15:0] FRAME_NUMBER_RST   = 16'h3FFF;
    localparam logic [15:0] FRAME_NUMBER_MAX   = 16'h3FFF;
    localparam logic [7:0]  QUEUE_SPACE_RST    = 8'h08;
    localparam logic [15:0] FIFO_SPACE_RST     = 16'h0100;

    // PHY clock select codes
    localparam logic [1:0] PHY_SEL_48MHZ = 2'h1;
    localparam logic [1:0] PHY_SEL_6MHZ  = 2'h2;

    // Timing
    localparam int CLK_MHZ         = 100;
    localparam int PHY_FAST_MHZ    = 48;
    localparam int PHY_SLOW_MHZ    = 6;
    localparam int FRAME_PERIOD_US = 1000;

    typedef struct packed {
        logic [7:0]  queue_top;
        logic [7:0]  queue_space;
        logic [15:0] fifo_space;
    } uhf_ptx_status_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } uhf_bus_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE      = 2'b00,
        BUS_WRITE     = 2'b01,
        BUS_READ_WAIT = 2'b10,
        BUS_READ_DONE = 2'b11
    } uhf_bus_state_t;

endpackage

/* rtl/uhf_frame_timer.sv */
`timescale 1ns/1ns
// Operation
// - Bit 2 set: enumerate full/low speed only; clear: highest speed device supports.
// - PHY clock select 01 gives 48 MHz, 10 gives 6 MHz in low speed only.
// - Reload bit 1 disables dynamic interval reload, 0 enables; set at initialization.
// - Frame interval counts PHY clocks between full-speed start-of-frames; resets to 0xEA60.
// - Unprogrammed frame interval is one millisecond times selected PHY clock frequency.
// - Remaining time decrements per PHY clock; at zero reloads and sends start-of-frame.
// - Frame number increments per start-of-frame, wraps to zero after 0x3FFF.
// - Read-only queue top shows odd frame, channel, type and final-request mark.
// - Periodic queue space reports free request entries 0 to 8, resets to 8.
// - Periodic FIFO space reports free words 0 to 512, resets to 0x0100.
// - A channel flag sets its summary bit and, if its mask bit is set, raises the host channels interrupt.
// - Summary bits follow only the per-channel interrupt registers' flags.
// - Sixteen mask bits gate each channel's contribution to the application interrupt.
module uhf_frame_timer (
    // Clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST_N,
    // AHB-Lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic [31:0]      O_HRDATA,
    // Port and channel logic
    input  wire logic        I_PORT_ENABLED,
    input  wire logic        I_PORT_LOW_SPEED,
    input  wire logic [15:0] I_CHANNEL_FLAGS,
    // Periodic queue and FIFO state
    input  wire logic [7:0]  I_QUEUE_TOP,
    input  wire logic [7:0]  I_QUEUE_SPACE,
    input  wire logic [15:0] I_FIFO_SPACE,
    // Host configuration and frame timing outputs
    output logic             O_FS_LS_ONLY,
    output logic [1:0]       O_PHY_CLOCK_SELECT,
    output logic             O_PHY_TICK,
    output logic             O_SOF,
    output logic [15:0]      O_FRAME_NUMBER,
    // Interrupts
    output logic             O_HOST_CHANNELS_IRQ,
    output logic             O_IRQ
);

    logic                   rst_sync1_reg;
    logic                   rst_n;
    uhf_pkg::uhf_bus_state_t bus_state_reg;
    uhf_pkg::uhf_bus_req_t  req_reg;
    logic                   fs_ls_only_support_reg;
    logic [1:0]             phy_clock_select_reg;
    logic                   frame_reload_control_reg;
    logic [15:0]            frame_interval_reg;
    logic                   interval_programmed_reg;
    logic [15:0]            frame_time_remaining_reg;
    logic [15:0]            frame_number_reg;
    logic [7:0]             phy_acc_reg;
    logic                   phy_tick_reg;
    logic                   sof_reg;
    uhf_pkg::uhf_ptx_status_t ptx_status_reg;
    logic [15:0]            channel_interrupt_summary_reg;
    logic [15:0]            channel_interrupt_mask_reg;
    logic [15:0]            channel_rise;
    logic [2:0]             irq_status_reg;
    logic [2:0]             irq_mask_reg;
    logic [2:0]             irq_event;
    logic [31:0]            hrdata_reg;
    logic                   addr_phase;
    logic                   wr_en;
    logic [7:0]             phy_mhz;
    logic [8:0]             phy_acc_next;
    logic [15:0]            interval_eff;
    logic                   frame_wrap;
    logic                   wr_config;
    logic                   wr_interval;
    logic                   wr_ch_mask;
    logic                   wr_irq_status;
    logic                   wr_irq_mask;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_sync1_reg <= 1'b0;
            rst_n         <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n         <= rst_sync1_reg;
        end
    end

    // PHY rate in MHz for a select code; reserved codes stop the PHY clock
    function automatic logic [7:0] sel_to_mhz(input logic [1:0] sel, input logic low_speed);
        logic [7:0] mhz;
        mhz = 8'h00;
        if (sel == uhf_pkg::PHY_SEL_48MHZ) begin
            mhz = 8'(uhf_pkg::PHY_FAST_MHZ);
        end else if (sel == uhf_pkg::PHY_SEL_6MHZ && low_speed) begin
            mhz = 8'(uhf_pkg::PHY_SLOW_MHZ);
        end
        return mhz;
    endfunction

    assign phy_mhz = sel_to_mhz(phy_clock_select_reg, I_PORT_LOW_SPEED);

    // AHB-Lite: writes complete with no wait, reads take one wait state so
    // a read right behind a write to the same register sees the new value.
    assign addr_phase  = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wr_en       = (bus_state_reg == uhf_pkg::BUS_WRITE) && req_reg.write;
    assign O_HREADYOUT = (bus_state_reg != uhf_pkg::BUS_READ_WAIT);
    assign O_HRESP     = 1'b0;
    assign O_HRDATA    = hrdata_reg;

    // One register's write strobe, valid in the data phase of its write
    function automatic logic write_hit(input logic       en,
                                       input logic [7:0] addr,
                                       input logic [7:0] target);
        return en && (addr == target);
    endfunction

    // Hwdata only stands in the data phase, so every write lands there
    assign wr_config     = write_hit(wr_en, req_reg.addr, uhf_pkg::OFF_HOST_CONFIG);
    assign wr_interval   = write_hit(wr_en, req_reg.addr, uhf_pkg::OFF_FRAME_INTERVAL);
    assign wr_ch_mask    = write_hit(wr_en, req_reg.addr, uhf_pkg::OFF_CH_MASK);
    assign wr_irq_status = write_hit(wr_en, req_reg.addr, uhf_pkg::OFF_IRQ_STATUS);
    assign wr_irq_mask   = write_hit(wr_en, req_reg.addr, uhf_pkg::OFF_IRQ_MASK);

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= uhf_pkg::BUS_IDLE;
            req_reg       <= '0;
        end else begin
            case (bus_state_reg)
                uhf_pkg::BUS_READ_WAIT: begin
                    bus_state_reg <= uhf_pkg::BUS_READ_DONE;
                end
                uhf_pkg::BUS_IDLE, uhf_pkg::BUS_WRITE, uhf_pkg::BUS_READ_DONE: begin
                    if (addr_phase) begin
                        req_reg.write <= I_HWRITE;
                        req_reg.addr  <= I_HADDR[7:0];
                        bus_state_reg <= I_HWRITE ? uhf_pkg::BUS_WRITE : uhf_pkg::BUS_READ_WAIT;
                    end else begin
                        bus_state_reg <= uhf_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    bus_state_reg <= uhf_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read as zero
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (bus_state_reg == uhf_pkg::BUS_READ_WAIT) begin
            case (req_reg.addr)
                uhf_pkg::OFF_HOST_CONFIG:
                    hrdata_reg <= {29'h0, fs_ls_only_support_reg, phy_clock_select_reg};
                uhf_pkg::OFF_FRAME_INTERVAL:
                    hrdata_reg <= {15'h0, frame_reload_control_reg, frame_interval_reg};
                uhf_pkg::OFF_FRAME_NUMBER:
                    hrdata_reg <= {frame_time_remaining_reg, frame_number_reg};
                uhf_pkg::OFF_PERIODIC_TX:
                    hrdata_reg <= ptx_status_reg;
                uhf_pkg::OFF_CH_SUMMARY:
                    hrdata_reg <= {16'h0, channel_interrupt_summary_reg};
                uhf_pkg::OFF_CH_MASK:
                    hrdata_reg <= {16'h0, channel_interrupt_mask_reg};
                uhf_pkg::OFF_IRQ_STATUS:
                    hrdata_reg <= {29'h0, irq_status_reg};
                uhf_pkg::OFF_IRQ_MASK:
                    hrdata_reg <= {29'h0, irq_mask_reg};
                default:
                    hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Host configuration; meant to be written once after power-on
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fs_ls_only_support_reg <= 1'b0;
            phy_clock_select_reg   <= 2'h0;
        end else if (wr_config) begin
            fs_ls_only_support_reg <= I_HWDATA[uhf_pkg::HCFG_FS_LS_ONLY_BIT];
            phy_clock_select_reg   <= I_HWDATA[1:0];
        end
    end

    assign O_FS_LS_ONLY       = fs_ls_only_support_reg;
    assign O_PHY_CLOCK_SELECT = phy_clock_select_reg;

    // Frame interval; a write marks it programmed so the 1 ms default is dropped
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_reload_control_reg <= 1'b0;
            frame_interval_reg       <= uhf_pkg::FRAME_INTERVAL_RST;
            interval_programmed_reg  <= 1'b0;
        end else if (wr_interval) begin
            frame_reload_control_reg <= I_HWDATA[uhf_pkg::HFIR_RELOAD_CTRL_BIT];
            frame_interval_reg       <= I_HWDATA[15:0];
            interval_programmed_reg  <= 1'b1;
        end
    end

    // Unprogrammed interval: PHY clocks in one frame period
    assign interval_eff = interval_programmed_reg ? frame_interval_reg
                        : 16'(phy_mhz * 16'(uhf_pkg::FRAME_PERIOD_US));

    // Fractional divider: average PHY rate without a second clock domain,
    // at the cost of one reference cycle of jitter per tick
    assign phy_acc_next = {1'b0, phy_acc_reg} + {1'b0, phy_mhz};

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            phy_acc_reg  <= 8'h00;
            phy_tick_reg <= 1'b0;
        end else if (phy_acc_next >= 9'(uhf_pkg::CLK_MHZ)) begin
            phy_acc_reg  <= 8'(phy_acc_next - 9'(uhf_pkg::CLK_MHZ));
            phy_tick_reg <= 1'b1;
        end else begin
            phy_acc_reg  <= phy_acc_next[7:0];
            phy_tick_reg <= 1'b0;
        end
    end

    assign O_PHY_TICK = phy_tick_reg;

    // Frame time remaining and start-of-frame
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_time_remaining_reg <= 16'h0000;
            sof_reg                  <= 1'b0;
        end else if (!I_PORT_ENABLED) begin
            frame_time_remaining_reg <= 16'h0000;
            sof_reg                  <= 1'b0;
        end else if (wr_interval && !frame_reload_control_reg) begin
            frame_time_remaining_reg <= I_HWDATA[15:0];
            sof_reg                  <= 1'b0;
        end else if (phy_tick_reg) begin
            if (frame_time_remaining_reg == 16'h0000) begin
                frame_time_remaining_reg <= interval_eff;
                sof_reg                  <= 1'b1;
            end else begin
                frame_time_remaining_reg <= frame_time_remaining_reg - 16'h0001;
                sof_reg                  <= 1'b0;
            end
        end else begin
            sof_reg <= 1'b0;
        end
    end

    assign O_SOF = sof_reg;

    // Frame number
    assign frame_wrap = sof_reg && (frame_number_reg == uhf_pkg::FRAME_NUMBER_MAX);

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_number_reg <= uhf_pkg::FRAME_NUMBER_RST;
        end else if (frame_wrap) begin
            frame_number_reg <= 16'h0000;
        end else if (sof_reg) begin
            frame_number_reg <= frame_number_reg + 16'h0001;
        end
    end

    assign O_FRAME_NUMBER = frame_number_reg;

    // Periodic queue and FIFO status sampled from the queue logic
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ptx_status_reg.queue_top   <= 8'h00;
            ptx_status_reg.queue_space <= uhf_pkg::QUEUE_SPACE_RST;
            ptx_status_reg.fifo_space  <= uhf_pkg::FIFO_SPACE_RST;
        end else begin
            ptx_status_reg.queue_top   <= I_QUEUE_TOP;
            ptx_status_reg.queue_space <= I_QUEUE_SPACE;
            ptx_status_reg.fifo_space  <= I_FIFO_SPACE;
        end
    end

    // Summary mirrors channel flags; software clears it only at the channel
    genvar ch;
    generate
        for (ch = 0; ch < uhf_pkg::NUM_CHANNELS; ch++) begin : g_channel
            always_ff @(posedge I_REF_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    channel_interrupt_summary_reg[ch] <= 1'b0;
                end else begin
                    channel_interrupt_summary_reg[ch] <= I_CHANNEL_FLAGS[ch];
                end
            end
            assign channel_rise[ch] = I_CHANNEL_FLAGS[ch] & ~channel_interrupt_summary_reg[ch];
        end
    endgenerate

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            channel_interrupt_mask_reg <= 16'h0000;
        end else if (wr_ch_mask) begin
            channel_interrupt_mask_reg <= I_HWDATA[15:0];
        end
    end

    assign O_HOST_CHANNELS_IRQ = |(channel_interrupt_summary_reg & channel_interrupt_mask_reg);

    // Block events: sticky, write one to clear, a same-cycle event wins
    assign irq_event[uhf_pkg::IRQ_SOF_BIT]        = sof_reg;
    assign irq_event[uhf_pkg::IRQ_FRAME_WRAP_BIT] = frame_wrap;
    assign irq_event[uhf_pkg::IRQ_CHANNEL_BIT]    = |(channel_rise & channel_interrupt_mask_reg);

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= 3'h0;
        end else if (wr_irq_status) begin
            irq_status_reg <= (irq_status_reg & ~I_HWDATA[2:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= 3'h0;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= I_HWDATA[2:0];
        end
    end

    assign O_IRQ = |(irq_status_reg & irq_mask_reg);

endmodule

/* bench/uhf_usb_peer.sv */
`timescale 1ns/1ns
module uhf_usb_peer (
    // Clock and frame marker
    input  wire logic        i_clk,
    input  wire logic        i_sof,
    // Commands from the bench
    input  wire logic        i_port_en,
    input  wire logic [15:0] i_set,
    input  wire logic [15:0] i_clr,
    input  wire logic [7:0]  i_qtop,
    input  wire logic [7:0]  i_qspace,
    input  wire logic [15:0] i_fspace,
    // Levels seen by the block, and the start-of-frame count for the bench
    output logic             o_port_en,
    output logic [15:0]      o_flags,
    output logic [7:0]       o_qtop,
    output logic [7:0]       o_qspace,
    output logic [15:0]      o_fspace,
    output int               o_sof_count
);
    initial begin
        {o_port_en, o_flags, o_qtop, o_sof_count} = '0;
        o_qspace = 8'h08;
        o_fspace = 16'h0100;
    end
    always @(posedge i_clk) begin
        o_port_en <= i_port_en;
        o_flags <= (o_flags & ~i_clr) | i_set;
        o_qtop <= i_qtop;
        // Counts beyond the documented range are never shown to the block
        o_qspace <= (i_qspace > 8'h08) ? 8'h08 : i_qspace;
        o_fspace <= (i_fspace > 16'h0200) ? 16'h0200 : i_fspace;
        o_sof_count <= o_sof_count + int'(i_sof);
    end
endmodule

/* bench/uhf_frame_timer_assertions.sv */
`timescale 1ns/1ns
module uhf_frame_timer_assertions (
    // Clock and reset
    input wire logic        I_REF_CLK,
    input wire logic        I_RST_N,
    // Watched block ports
    input wire logic        I_PORT_ENABLED,
    input wire logic        I_PORT_LOW_SPEED,
    input wire logic [15:0] I_CHANNEL_FLAGS,
    input wire logic [1:0]  O_PHY_CLOCK_SELECT,
    input wire logic        O_PHY_TICK,
    input wire logic        O_SOF,
    input wire logic [15:0] O_FRAME_NUMBER,
    input wire logic        O_HOST_CHANNELS_IRQ
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_no_clock;
        (O_PHY_CLOCK_SELECT == 2'h0 || O_PHY_CLOCK_SELECT == 2'h3 ||
         (O_PHY_CLOCK_SELECT == 2'h2 && !I_PORT_LOW_SPEED))[*3];
    endsequence
    sequence s_sof_launch;
        O_PHY_TICK ##1 O_SOF;
    endsequence
    a_reserved_no_tick: assert property (s_no_clock |-> !O_PHY_TICK) else $error("tick on reserved code");
    a_tick_rate_cap: assert property (O_PHY_TICK |=> !O_PHY_TICK) else $error("ticks too dense");
    a_sof_from_tick: assert property (O_SOF |-> $past(O_PHY_TICK)) else $error("sof without tick");
    a_sof_spacing: assert property (s_sof_launch |=> !O_SOF[*8]) else $error("sof too soon");
    a_frame_advance: assert property (O_SOF |=> O_FRAME_NUMBER ==
        (($past(O_FRAME_NUMBER) == 16'h3FFF) ? 16'h0000 : $past(O_FRAME_NUMBER) + 16'h0001))
        else $error("frame number step wrong");
    a_frame_hold: assert property ($changed(O_FRAME_NUMBER) |-> $past(O_SOF)) else $error("frame moved");
    a_port_off_quiet: assert property ((!I_PORT_ENABLED)[*3] |-> !O_SOF) else $error("sof while port off");
    a_chan_irq_cause: assert property (O_HOST_CHANNELS_IRQ |-> $past(I_CHANNEL_FLAGS) != 16'h0000)
        else $error("channel irq without flag");
endmodule
bind uhf_frame_timer uhf_frame_timer_assertions i_chk (.I_REF_CLK, .I_RST_N, .I_PORT_ENABLED, .I_PORT_LOW_SPEED,
    .I_CHANNEL_FLAGS, .O_PHY_CLOCK_SELECT, .O_PHY_TICK, .O_SOF, .O_FRAME_NUMBER, .O_HOST_CHANNELS_IRQ);

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0, p_port = 1'b0, low_speed = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'hA1A6;
    logic [1:0]  htrans = 2'h0, phy_sel;
    logic        hreadyout, fs_ls, tick, sof, ch_irq, irq, port_en, hresp;
    logic [15:0] frame_num, flags, fspace, fn, p_fspace = 16'h0100, p_set = 16'h0, p_clr = 16'h0, e_fl, e_fs, mask;
    logic [7:0]  qtop, qspace, p_qtop = 8'h0, p_qspace = 8'h08, e_qt, e_qs;
    logic [31:0] rst_tab [9] = '{32'h0, 32'h0000EA60, 32'h00003FFF, 32'h00080100, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int          miscompares = 0, total_checks = 0, n, cnt, base;
    always #5 clk = ~clk;
    uhf_frame_timer i_uhf_frame_timer (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
        .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_HRDATA(hrdata), .I_PORT_ENABLED(port_en),
        .I_PORT_LOW_SPEED(low_speed), .I_CHANNEL_FLAGS(flags), .I_QUEUE_TOP(qtop), .I_QUEUE_SPACE(qspace),
        .I_FIFO_SPACE(fspace), .O_FS_LS_ONLY(fs_ls), .O_PHY_CLOCK_SELECT(phy_sel), .O_PHY_TICK(tick),
        .O_SOF(sof), .O_FRAME_NUMBER(frame_num), .O_HOST_CHANNELS_IRQ(ch_irq), .O_IRQ(irq));
    uhf_usb_peer i_uhf_usb_peer (.i_clk(clk), .i_sof(sof), .i_port_en(p_port), .i_set(p_set), .i_clr(p_clr),
        .i_qtop(p_qtop), .i_qspace(p_qspace), .i_fspace(p_fspace), .o_port_en(port_en), .o_flags(flags),
        .o_qtop(qtop), .o_qspace(qspace), .o_fspace(fspace), .o_sof_count(cnt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Ticks expected in 200 cycles of 100 MHz
    function automatic int ticks_for(input logic [1:0] code, input logic low);
        return (code == 2'h1) ? 96 : (code == 2'h2 && low) ? 12 : 0;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_for(input logic want_sof);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((want_sof ? sof : hreadyout) !== 1'b1 && n < 3000);
        if ((want_sof ? sof : hreadyout) !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_for(1'b0);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_for(1'b0);
        rd = hrdata;
    endtask
    // Ticks after one frame start up to the next
    task automatic sof_gap(output int t);
        wait_for(1'b1);
        fn = frame_num;
        t = 0;
        for (int c = 0; c < 3000 && !(c > 0 && sof === 1'b1); c++) begin
            @(posedge clk);
            t += int'(tick === 1'b1 && sof !== 1'b1);
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check("reset value", rd, rst_tab[i]);
        end
        for (int c = 0; c < 8; c++) begin
            low_speed <= c[2];
            bus(1'b1, uhf_pkg::OFF_HOST_CONFIG, {29'h0, c[0], c[1:0]});
            @(posedge clk);
            check("fs ls only", fs_ls, c[0]);
            check("clock select", phy_sel, c[1:0]);
            repeat (5) @(posedge clk);
            n = 0;
            repeat (200) @(posedge clk) n += int'(tick === 1'b1);
            check("tick count", n >= ticks_for(c[1:0], c[2]) - 1 && n <= ticks_for(c[1:0], c[2]) + 1, 1'b1);
        end
        // Fresh start after the sweep, which left the reserved clock select code 11
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, uhf_pkg::OFF_HOST_CONFIG, 32'h0);
        check("config after reset", rd, 32'h0);
        low_speed <= 1'b0;
        bus(1'b1, uhf_pkg::OFF_HOST_CONFIG, 32'h5);
        p_port <= 1'b1;
        wait_for(1'b1);
        bus(1'b0, uhf_pkg::OFF_FRAME_NUMBER, 32'h0);
        check("frame wrap", rd[15:0], 16'h0000);
        check("default interval", rd[31:16] <= 16'hBB80 && rd[31:16] >= 16'hBB76, 1'b1);
        bus(1'b1, uhf_pkg::OFF_FRAME_INTERVAL, 32'h14);
        sof_gap(n);
        check("sof gap", n, 21);
        check("frame step", frame_num, fn + 16'h1);
        bus(1'b1, uhf_pkg::OFF_FRAME_INTERVAL, 32'h0001001E);
        bus(1'b0, uhf_pkg::OFF_FRAME_INTERVAL, 32'h0);
        check("interval reg", rd, 32'h0001001E);
        sof_gap(n);
        check("reloaded gap", n, 31);
        bus(1'b1, uhf_pkg::OFF_IRQ_MASK, 32'h1);
        @(posedge clk);
        check("sof irq", irq, 1'b1);
        wait_for(1'b1);
        bus(1'b1, uhf_pkg::OFF_IRQ_STATUS, 32'h1);
        @(posedge clk);
        check("irq cleared", irq, 1'b0);
        bus(1'b0, uhf_pkg::OFF_IRQ_STATUS, 32'h0);
        check("irq status", rd, 32'h2);
        p_port <= 1'b0;
        repeat (5) @(posedge clk);
        bus(1'b0, uhf_pkg::OFF_FRAME_NUMBER, 32'h0);
        check("remaining idle", rd[31:16], 16'h0);
        base = cnt;
        repeat (300) @(posedge clk);
        check("no sof", cnt, base);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            e_fl = (k == 0) ? 16'h8001 : seed[15:0];
            e_qt = seed[31:24];
            mask = seed[23:8];
            seed = lfsr(seed);
            e_qs = (k == 0) ? 8'h00 : 8'(seed[7:0] % 9);
            e_fs = (k == 0) ? 16'h0200 : 16'(seed[31:16] % 513);
            p_clr <= 16'hFFFF;
            p_set <= e_fl;
            p_qtop <= e_qt;
            p_qspace <= e_qs;
            p_fspace <= e_fs;
            @(posedge clk);
            p_clr <= 16'h0;
            p_set <= 16'h0;
            repeat (3) @(posedge clk);
            bus(1'b0, uhf_pkg::OFF_CH_SUMMARY, 32'h0);
            check("summary", rd, {16'h0, e_fl});
            bus(1'b0, uhf_pkg::OFF_PERIODIC_TX, 32'h0);
            check("ptx status", rd, {e_qt, e_qs, e_fs});
            check("ptx response", hresp, 1'b0);
            bus(1'b1, uhf_pkg::OFF_CH_MASK, {16'h0, mask});
            @(posedge clk);
            check("channel irq", ch_irq, |(e_fl & mask));
        end
        p_clr <= 16'hFFFF;
        repeat (4) @(posedge clk);
        bus(1'b0, uhf_pkg::OFF_CH_SUMMARY, 32'h0);
        check("summary cleared", rd, 32'h0);
        wrap_up();
    end
endmodule
